// ==== msc_pkg.sv ====
// shared constants, modes and carriers of the service and context switch engine
package msc_pkg;

    localparam int NCH    = 16;
    localparam int CW     = 4;
    localparam int BANK_W = 3;

    // register byte offsets
    localparam logic [11:0] A_CTRL  = 12'h000;
    localparam logic [11:0] A_STAT  = 12'h004;
    localparam logic [11:0] A_MASK  = 12'h008;
    localparam logic [11:0] A_STATE = 12'h00C;
    localparam logic [3:0]  CH_PAGE = 4'h1;
    localparam logic [1:0]  R_MODE  = 2'h0;
    localparam logic [1:0]  R_SFRP  = 2'h1;
    localparam logic [1:0]  R_BUFFER_POINTER  = 2'h2;
    localparam logic [1:0]  R_CNT   = 2'h3;

    // control and status fields
    localparam int CTRL_GIE  = 0;
    localparam int ST_VINT   = 0;
    localparam int ST_CS     = 1;
    localparam int ST_RETERR = 2;
    localparam int ST_W      = 3;
    localparam int MD_W      = 6;
    localparam int MD_WORD   = 3;
    localparam int MD_TOSFR  = 4;
    localparam int MD_CSEN   = 5;
    localparam int CNT_LSB   = 0;
    localparam int LDB_LSB   = 16;

    // vector table: source n has its entry at VT_FIRST + 2n
    localparam logic [15:0] VT_FIRST = 16'h0006;
    localparam logic [15:0] ONE      = 16'h0001;
    localparam logic [15:0] TWO      = 16'h0002;
    localparam logic [7:0]  CNT_LAST = 8'h01;
    localparam logic [7:0]  CNT_ZERO = 8'h00;

    typedef enum logic [2:0] {
        MD_OFF,
        MD_BLOCK_MOVE_SERVICE,
        MD_BLOCK_MOVE_SERVICE_WITH_POINTER,
        MD_DIFFERENCE_SERVICE,
        MD_DIFFERENCE_SERVICE_WITH_POINTER
    } msc_mode_t;

    typedef enum {
        ST_IDLE,
        ST_START,
        ST_SRC,
        ST_DST,
        ST_DIF_RD,
        ST_VT,
        ST_SWITCH
    } msc_state_t;

    typedef struct packed {
        logic        we;
        logic        word;
        logic [15:0] addr;
        logic [15:0] data;
    } msc_mreq_t;

    typedef struct packed {
        logic [BANK_W-1:0] bank;
        logic [15:0]       new_pc;
        logic [15:0]       save_pc;
        logic [15:0]       save_psw;
        logic              from_brk;
    } msc_cs_t;

endpackage : msc_pkg

// ==== msc_engine.sv ====
// data service and register bank context switch engine with AHB-Lite registers
//
// How it works
// - each accepted request of a block move channel moves one item between buffer and pointed SFR, either way.
// - a block move item is one byte or one 16-bit word, chosen per channel.
// - every channel holds its own 8-bit transfer counter.
// - the counter drops by one on each executed block move or difference service.
// - a counter at zero stops hardware service and the source raises an ordinary vectored request instead, or switches context if global and switch enable are set.
// - the pointer block move advances the buffer pointer by one for bytes and two for words.
// - difference service writes current SFR value minus the previous sample into the buffer.
// - after each difference the current value becomes the previous sample.
// - difference service always works on 16-bit registers.
// - pointer difference service writes to buffer pointer minus twice the counter plus two.
// - pointer difference service never changes the buffer pointer.
// - a request switches context only with global enable and its own switch enable set.
// - an interrupt switch takes its bank from the low three bits of the vector table word.
// - a switch loads the bank's vector into the PC while saving old PC and status into the bank.
// - fetch resumes at the newly loaded PC.
// - a break-to-bank instruction selects the bank from the low three operand bits only.
// - the return operation must match the start source, interrupt or break.
`timescale 1ns/1ps
`default_nettype none

module msc_engine
    import msc_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // peripheral interrupt requests, one-cycle pulses
    input  wire logic [NCH-1:0]    irq_req,
    // memory and sfr access port
    output var msc_mreq_t          mem_req,
    output logic                   mem_valid,
    input  wire logic              mem_ack,
    input  wire logic [15:0]       mem_rdata,
    // cpu core and register banks
    input  wire logic [15:0]       cpu_pc,
    input  wire logic [15:0]       cpu_psw,
    input  wire logic [15:0]       bank_vec,
    input  wire logic              brk_req,
    input  wire logic [7:0]        brk_operand,
    input  wire logic              ret_req,
    input  wire logic              ret_is_brk,
    output logic      [BANK_W-1:0] bank_sel,
    output var msc_cs_t            cs_info,
    output logic                   cs_stb,
    output logic                   vint_stb,
    output logic      [CW-1:0]     vint_idx,
    output logic                   ret_ok,
    output logic                   irq
);

    function automatic logic ch_hit(input logic [11:0] a, input int c,
                                    input logic [1:0] r);
        ch_hit = (a[11:8] == CH_PAGE) && (a[7:4] == CW'(c)) && (a[3:2] == r);
    endfunction : ch_hit

    function automatic logic [CW-1:0] first_set(input logic [NCH-1:0] v);
        first_set = '0;
        for (int k = NCH - 1; k >= 0; k--) begin
            if (v[k]) first_set = CW'(k);
        end
    endfunction : first_set

    // control and status
    logic              gie_r;
    logic [ST_W-1:0]   stat_r;
    logic [ST_W-1:0]   mask_r;
    logic              ret_err_r;
    // channel state
    logic [MD_W-1:0]   mode_r [NCH];
    logic [15:0]       sfrp_r [NCH];
    logic [15:0]       buffer_pointer_r [NCH];
    logic [7:0]        cnt_r  [NCH];
    logic [15:0]       ldb_r  [NCH];
    logic [NCH-1:0]    pend_r;
    // engine
    msc_state_t        st_r;
    logic [CW-1:0]     cur_r;
    logic              is_brk_r;
    logic              cs_act_r;
    logic              cs_src_r;
    // bus data phase
    logic              wr_q_r;
    logic [11:0]       wa_q_r;

    // bus decode; no wait states, so hready only follows this slave
    wire        addr_ph = hsel && htrans[1] && hready;
    wire [11:0] ra      = haddr[11:0];
    wire [CW-1:0] rch   = ra[7:4];
    wire [31:0] wd      = hwdata;
    wire        w_ctrl  = wr_q_r && (wa_q_r == A_CTRL);
    wire        w_stat  = wr_q_r && (wa_q_r == A_STAT);
    wire        w_mask  = wr_q_r && (wa_q_r == A_MASK);

    wire [31:0] ch_word =
        (ra[3:2] == R_MODE) ? {26'h0, mode_r[rch]} :
        (ra[3:2] == R_SFRP) ? {16'h0, sfrp_r[rch]} :
        (ra[3:2] == R_BUFFER_POINTER) ? {16'h0, buffer_pointer_r[rch]} :
                              {ldb_r[rch], 8'h00, cnt_r[rch]};
    wire [31:0] st_word = {pend_r, 10'h0, bank_sel, cs_src_r, cs_act_r,
                           st_r == ST_IDLE};
    wire [31:0] rd_mux =
        (ra[11:8] == CH_PAGE) ? ch_word :
        (ra == A_CTRL)        ? {31'h0, gie_r} :
        (ra == A_STAT)        ? {29'h0, stat_r} :
        (ra == A_MASK)        ? {29'h0, mask_r} :
        (ra == A_STATE)       ? st_word :
                                32'h0;

    // current channel view
    wire msc_mode_t  c_mode = msc_mode_t'(mode_r[cur_r][2:0]);
    wire        c_dif  = (c_mode == MD_DIFFERENCE_SERVICE) ||
                         (c_mode == MD_DIFFERENCE_SERVICE_WITH_POINTER);
    wire        c_blkp = (c_mode == MD_BLOCK_MOVE_SERVICE_WITH_POINTER);
    wire        c_word = c_dif || mode_r[cur_r][MD_WORD];
    wire        c_tosf = mode_r[cur_r][MD_TOSFR];
    wire [15:0] c_sz   = c_word ? TWO : ONE;
    wire [15:0] c_buffer_pointer = buffer_pointer_r[cur_r];
    wire [15:0] c_cnt  = {8'h00, cnt_r[cur_r]};
    wire [15:0] c_sfr  = sfrp_r[cur_r];
    wire [15:0] dif_at = c_buffer_pointer - (c_cnt << 1) + TWO;
    wire [15:0] idx_at = c_buffer_pointer - (c_word ? c_cnt << 1 : c_cnt) + c_sz;
    wire [15:0] buf_at = c_dif ? dif_at : (c_blkp ? c_buffer_pointer : idx_at);
    wire        c_svc  = (c_mode != MD_OFF) && (cnt_r[cur_r] != CNT_ZERO);
    wire        c_csgo = gie_r && mode_r[cur_r][MD_CSEN];
    wire        c_last = cnt_r[cur_r] == CNT_LAST;
    wire [15:0] vt_at  = VT_FIRST + {11'h0, cur_r, 1'b0};
    wire        xfer_done = mem_ack && (st_r == ST_DST);
    wire        ldb_we    = mem_ack && (st_r == ST_DIF_RD);
    wire        take      = (st_r == ST_IDLE) && !brk_req && (|pend_r);
    wire [CW-1:0] pick    = first_set(pend_r);
    wire [ST_W-1:0] ev    = {ret_err_r, cs_stb, vint_stb};

    // bus slave
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_q_r    <= 1'b0;
            wa_q_r    <= '0;
            hrdata    <= '0;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            wr_q_r    <= addr_ph && hwrite;
            wa_q_r    <= addr_ph ? ra : wa_q_r;
            hrdata    <= (addr_ph && !hwrite) ? rd_mux : '0;
        end
    end

    // global control, sticky status, mask; a new event beats a clear
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            gie_r  <= 1'b0;
            stat_r <= '0;
            mask_r <= '0;
            irq    <= 1'b0;
        end else begin
            if (w_ctrl) gie_r <= wd[CTRL_GIE];
            if (w_mask) mask_r <= wd[ST_W-1:0];
            stat_r <= (stat_r & ~(w_stat ? wd[ST_W-1:0] : '0)) | ev;
            irq    <= |(stat_r & mask_r);
        end
    end

    // per-source state; a request pulse beats its own acceptance
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                pend_r[i] <= 1'b0;
                mode_r[i] <= '0;
                sfrp_r[i] <= '0;
                buffer_pointer_r[i] <= '0;
                cnt_r[i]  <= '0;
                ldb_r[i]  <= '0;
            end else begin
                pend_r[i] <= irq_req[i] || (pend_r[i] && !(take && pick == CW'(i)));
                if (wr_q_r && ch_hit(wa_q_r, i, R_MODE)) mode_r[i] <= wd[MD_W-1:0];
                if (wr_q_r && ch_hit(wa_q_r, i, R_SFRP)) sfrp_r[i] <= wd[15:0];
                if (xfer_done && cur_r == CW'(i)) begin
                    cnt_r[i] <= cnt_r[i] - CNT_LAST;
                    if (c_blkp) buffer_pointer_r[i] <= c_buffer_pointer + c_sz;
                end else begin
                    if (wr_q_r && ch_hit(wa_q_r, i, R_BUFFER_POINTER)) buffer_pointer_r[i] <= wd[15:0];
                    if (wr_q_r && ch_hit(wa_q_r, i, R_CNT)) cnt_r[i] <= wd[CNT_LSB +: 8];
                end
                if (ldb_we && cur_r == CW'(i)) begin
                    ldb_r[i] <= mem_rdata;
                end else if (wr_q_r && ch_hit(wa_q_r, i, R_CNT)) begin
                    ldb_r[i] <= wd[LDB_LSB +: 16];
                end
            end
        end
    end

    // service and switch sequencer
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r      <= ST_IDLE;
            cur_r     <= '0;
            is_brk_r  <= 1'b0;
            cs_act_r  <= 1'b0;
            cs_src_r  <= 1'b0;
            ret_err_r <= 1'b0;
            bank_sel  <= '0;
            mem_req   <= '0;
            mem_valid <= 1'b0;
            cs_info   <= '0;
            cs_stb    <= 1'b0;
            vint_stb  <= 1'b0;
            vint_idx  <= '0;
            ret_ok    <= 1'b0;
        end else begin
            cs_stb    <= 1'b0;
            vint_stb  <= 1'b0;
            ret_ok    <= 1'b0;
            ret_err_r <= 1'b0;
            if (mem_ack) mem_valid <= 1'b0;
            case (st_r)
                ST_IDLE: begin
                    if (brk_req) begin
                        bank_sel <= brk_operand[BANK_W-1:0];
                        is_brk_r <= 1'b1;
                        st_r     <= ST_SWITCH;
                    end else if (|pend_r) begin
                        cur_r <= pick;
                        st_r  <= ST_START;
                    end
                end
                ST_START: begin
                    mem_valid <= c_svc || c_csgo;
                    if (c_svc && c_dif) begin
                        mem_req <= '{1'b0, 1'b1, c_sfr, 16'h0};
                        st_r    <= ST_DIF_RD;
                    end else if (c_svc) begin
                        mem_req <= '{1'b0, c_word, c_tosf ? buf_at : c_sfr, 16'h0};
                        st_r    <= ST_SRC;
                    end else if (c_csgo) begin
                        mem_req  <= '{1'b0, 1'b1, vt_at, 16'h0};
                        is_brk_r <= 1'b0;
                        st_r     <= ST_VT;
                    end else begin
                        vint_stb <= 1'b1;
                        vint_idx <= cur_r;
                        st_r     <= ST_IDLE;
                    end
                end
                ST_SRC: begin
                    if (mem_ack) begin
                        mem_valid <= 1'b1;
                        mem_req   <= '{1'b1, c_word, c_tosf ? c_sfr : buf_at,
                                       c_word ? mem_rdata : {8'h00, mem_rdata[7:0]}};
                        st_r      <= ST_DST;
                    end
                end
                ST_DIF_RD: begin
                    if (mem_ack) begin
                        mem_valid <= 1'b1;
                        mem_req   <= '{1'b1, 1'b1, buf_at, mem_rdata - ldb_r[cur_r]};
                        st_r      <= ST_DST;
                    end
                end
                ST_DST: begin
                    if (mem_ack) begin
                        vint_stb <= c_last;
                        vint_idx <= cur_r;
                        st_r     <= ST_IDLE;
                    end
                end
                ST_VT: begin
                    if (mem_ack) begin
                        bank_sel <= mem_rdata[BANK_W-1:0];
                        st_r     <= ST_SWITCH;
                    end
                end
                ST_SWITCH: begin
                    // bank_vec already reflects bank_sel chosen last cycle
                    cs_info  <= '{bank_sel, bank_vec, cpu_pc, cpu_psw, is_brk_r};
                    cs_stb   <= 1'b1;
                    cs_act_r <= 1'b1;
                    cs_src_r <= is_brk_r;
                    st_r     <= ST_IDLE;
                end
                default: st_r <= ST_IDLE;
            endcase
            // single level of tracking: a nested switch overwrites the source
            if (ret_req && st_r != ST_SWITCH) begin
                if (cs_act_r && ret_is_brk == cs_src_r) begin
                    ret_ok   <= 1'b1;
                    cs_act_r <= 1'b0;
                end else begin
                    ret_err_r <= 1'b1;
                end
            end
        end
    end

endmodule : msc_engine

`default_nettype wire

// ==== msc_assertions.sv ====
// port checker of the service and context switch engine
`timescale 1ns/1ps
`default_nettype none
module msc_assertions
    import msc_pkg::*;
(
    // clock and reset
    input wire logic              ref_clk,
    input wire logic              reset_n,
    // register bus
    input wire logic              hsel,
    input wire logic [1:0]        htrans,
    input wire logic              hready,
    input wire logic [31:0]       hrdata,
    input wire logic              hreadyout,
    // memory port
    input wire msc_mreq_t         mem_req,
    input wire logic              mem_valid,
    input wire logic              mem_ack,
    // core side
    input wire logic [15:0]       cpu_pc,
    input wire logic [15:0]       cpu_psw,
    input wire logic [15:0]       bank_vec,
    input wire logic [7:0]        brk_operand,
    input wire logic [BANK_W-1:0] bank_sel,
    input wire msc_cs_t           cs_info,
    input wire logic              cs_stb,
    input wire logic              vint_stb
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence acc_wait;
        mem_valid && !mem_ack;
    endsequence
    sequence bus_free;
        !(hsel && htrans[1] && hready);
    endsequence

    ready_high_a: assert property ($past(reset_n) |-> hreadyout)
        else $error("hreadyout low after reset");
    rdata_idle_a: assert property (bus_free |=> hrdata == 32'h0)
        else $error("read data outside data phase");
    req_hold_a: assert property (acc_wait |=> mem_valid && $stable(mem_req))
        else $error("access changed before ack");
    cs_vec_a: assert property (cs_stb |-> cs_info.bank == bank_sel && cs_info.new_pc == bank_vec)
        else $error("switch vector not from selected bank");
    // pc and psw are latched one edge before the strobe shows
    cs_save_a: assert property (cs_stb |-> cs_info.save_pc == $past(cpu_pc) && cs_info.save_psw == $past(cpu_psw))
        else $error("switch saved wrong pc or psw");
    // operand is taken two edges before the strobe shows
    brk_bank_a: assert property (cs_stb && cs_info.from_brk |-> cs_info.bank == $past(brk_operand[2:0], 2))
        else $error("break bank not low operand bits");
    cs_pulse_a: assert property (cs_stb |=> !cs_stb)
        else $error("switch strobe longer than one cycle");
    cs_hold_a: assert property (!cs_stb |-> $stable(cs_info))
        else $error("switch info changed without strobe");
    vint_pulse_a: assert property (vint_stb |=> !vint_stb)
        else $error("vectored strobe longer than one cycle");
endmodule : msc_assertions
`default_nettype wire

// ==== msc_mem_model.sv ====
// memory, sfr and register bank stand-in at the far side of the engine
`timescale 1ns/1ps
`default_nettype none
module msc_mem_model
    import msc_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    // slow answers when set
    input  wire logic              stall,
    // access port
    input  wire msc_mreq_t         mem_req,
    input  wire logic              mem_valid,
    output logic                   mem_ack,
    output logic      [15:0]       mem_rdata,
    // bank side
    input  wire logic [BANK_W-1:0] bank_sel,
    output logic      [15:0]       bank_vec
);
    logic      [7:0] m [0:511];
    logic      [1:0] wait_r;
    wire logic [8:0] a = mem_req.addr[8:0];

    // each bank keeps its vector at 0x1000 plus 0x100 per bank
    assign bank_vec = {5'h02, bank_sel, 8'h00};

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_ack <= 1'b0;
            wait_r <= 2'h0;
            mem_rdata <= 16'h0000;
        end else if (mem_valid && !mem_ack && wait_r == {stall, stall}) begin
            mem_ack <= 1'b1;
            wait_r <= 2'h0;
            mem_rdata <= {mem_req.word ? m[a + 9'h1] : 8'h00, m[a]};
            if (mem_req.we) m[a] <= mem_req.data[7:0];
            if (mem_req.we && mem_req.word) m[a + 9'h1] <= mem_req.data[15:8];
        end else begin
            mem_ack <= 1'b0;
            wait_r <= (mem_valid && !mem_ack) ? wait_r + 2'h1 : 2'h0;
            // released lines invert every cycle so a sample one cycle late never sees the old word
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule : msc_mem_model
`default_nettype wire

// ==== msc_engine_tb.sv ====
// self-checking bench of the service and context switch engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module msc_engine_tb
    import msc_pkg::*;
;
    logic              ref_clk, reset_n, hsel, hwrite, hreadyout, stall, mem_valid, mem_ack;
    logic              brk_req, ret_req, ret_is_brk, cs_stb, vint_stb, ret_ok, irq, hresp;
    logic [1:0]        htrans;
    logic [7:0]        brk_operand;
    logic [CW-1:0]     vint_idx;
    logic [BANK_W-1:0] bank_sel;
    logic [15:0]       irq_req, mem_rdata, cpu_pc, cpu_psw, bank_vec;
    logic [31:0]       haddr, hwdata, hrdata, q;
    msc_mreq_t         mem_req;
    msc_cs_t           cs_info, cs_q;
    int                n_mismatch, comparisons, n_ack, n_vint, n_cs, n_ret, k;

    msc_engine dut (.ref_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq_req, .mem_req, .mem_valid,
        .mem_ack, .mem_rdata, .cpu_pc, .cpu_psw, .bank_vec, .brk_req, .brk_operand, .ret_req,
        .ret_is_brk, .bank_sel, .cs_info, .cs_stb, .vint_stb, .vint_idx, .ret_ok, .irq);
    msc_mem_model mdl (.ref_clk, .reset_n, .stall, .mem_req, .mem_valid, .mem_ack, .mem_rdata,
        .bank_sel, .bank_vec);

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (mem_valid && mem_ack) n_ack++;
        if (vint_stb) n_vint++;
        if (ret_ok) n_ret++;
        if (cs_stb) cs_q = cs_info;
        if (cs_stb) n_cs++;
    end

    task automatic bus(input logic w, input logic [31:0] a, d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        q = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask : bus

    task automatic rc(input logic [31:0] a, e);
        bus(1'b0, a, 32'h0);
        `CHK($sformatf("reg %h", a), e, q)
    endtask : rc

    function automatic logic [31:0] ch(input logic [3:0] n, input logic [1:0] r);
        return {20'h0, CH_PAGE, n, r, 2'h0};
    endfunction : ch

    task automatic poke(input logic [8:0] a, input logic [15:0] w);
        mdl.m[a] = w[7:0];
        mdl.m[a + 9'h1] = w[15:8];
    endtask : poke

    // n of 16 stands for the break-to-bank request
    task automatic fire(input int n, na, nv, nc);
        na += n_ack;
        nv += n_vint;
        nc += n_cs;
        @(posedge ref_clk);
        irq_req <= 16'h1 << n;
        brk_req <= (n == 16);
        @(posedge ref_clk);
        irq_req <= 16'h0;
        brk_req <= 1'b0;
        while (n_ack < na || n_vint < nv || n_cs < nc) @(posedge ref_clk);
    endtask : fire

    task automatic ret(input logic b);
        @(posedge ref_clk);
        ret_req <= 1'b1;
        ret_is_brk <= b;
        @(posedge ref_clk);
        ret_req <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask : ret

    task automatic end_of_test();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        {hsel, hwrite, stall, brk_req, ret_req, ret_is_brk, reset_n, htrans, haddr, hwdata} = '0;
        irq_req = 16'h0;
        cpu_pc = 16'h4321;
        cpu_psw = 16'h0F0F;
        brk_operand = 8'hFA;
        poke(9'h40, 16'h00A5);
        poke(9'h120, 16'hBEEF);
        poke(9'h60, 16'h1234);
        poke(9'h0C, 16'h00FD);
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        rc(A_CTRL, 32'h0);
        rc(A_STATE, 32'h1);
        bus(1'b1, 32'h80, 32'hFFFFFFFF);
        rc(32'h80, 32'h0);
        bus(1'b1, A_MASK, 32'h7);
        bus(1'b1, ch(0, R_SFRP), 32'h40);
        bus(1'b1, ch(0, R_BUFFER_POINTER), 32'h100);
        bus(1'b1, ch(0, R_CNT), 32'h2);
        bus(1'b1, ch(0, R_MODE), 32'h1);
        fire(0, 2, 0, 0);
        `CHK("byte 1", 8'hA5, mdl.m[9'hFF])
        rc(ch(0, R_CNT), 32'h1);
        poke(9'h40, 16'h005A);
        fire(0, 2, 1, 0);
        `CHK("byte 2", 8'h5A, mdl.m[9'h100])
        `CHK("vint source", 4'h0, vint_idx)
        rc(ch(0, R_CNT), 32'h0);
        rc(A_STAT, 32'h1);
        `CHK("irq set", 1'b1, irq)
        bus(1'b1, A_MASK, 32'h0);
        rc(A_MASK, 32'h0);
        `CHK("irq masked", 1'b0, irq)
        bus(1'b1, A_MASK, 32'h7);
        bus(1'b1, A_STAT, 32'h1);
        rc(A_STAT, 32'h0);
        `CHK("irq clear", 1'b0, irq)
        k = n_ack;
        fire(0, 0, 1, 0);
        `CHK("no service at zero", k, n_ack)
        stall <= 1'b1;
        bus(1'b1, ch(1, R_SFRP), 32'h50);
        bus(1'b1, ch(1, R_BUFFER_POINTER), 32'h120);
        bus(1'b1, ch(1, R_CNT), 32'h3);
        bus(1'b1, ch(1, R_MODE), 32'h1A);
        fire(1, 2, 0, 0);
        `CHK("word to sfr", 16'hBEEF, {mdl.m[9'h51], mdl.m[9'h50]})
        rc(ch(1, R_BUFFER_POINTER), 32'h122);
        rc(ch(1, R_CNT), 32'h2);
        bus(1'b1, ch(2, R_SFRP), 32'h60);
        bus(1'b1, ch(2, R_BUFFER_POINTER), 32'h180);
        bus(1'b1, ch(2, R_CNT), 32'h10000002);
        bus(1'b1, ch(2, R_MODE), 32'h4);
        fire(2, 2, 0, 0);
        `CHK("diff 1", 16'h0234, {mdl.m[9'h17F], mdl.m[9'h17E]})
        rc(ch(2, R_CNT), 32'h12340001);
        rc(ch(2, R_BUFFER_POINTER), 32'h180);
        poke(9'h60, 16'h1300);
        fire(2, 2, 1, 0);
        `CHK("diff 2", 16'h00CC, {mdl.m[9'h181], mdl.m[9'h180]})
        `CHK("vint source", 4'h2, vint_idx)
        stall <= 1'b0;
        bus(1'b1, ch(4, R_SFRP), 32'h60);
        bus(1'b1, ch(4, R_BUFFER_POINTER), 32'h1A0);
        bus(1'b1, ch(4, R_CNT), 32'h10000001);
        bus(1'b1, ch(4, R_MODE), 32'h3);
        fire(4, 2, 1, 0);
        `CHK("diff plain", 16'h0300, {mdl.m[9'h1A1], mdl.m[9'h1A0]})
        bus(1'b1, A_STAT, 32'h7);
        bus(1'b1, A_CTRL, 32'h1);
        bus(1'b1, ch(3, R_MODE), 32'h20);
        fire(3, 1, 0, 1);
        `CHK("irq switch", {3'h5, 16'h1500, 16'h4321, 16'h0F0F, 1'b0}, cs_q)
        rc(A_STATE, 32'h2B);
        ret(1'b0);
        `CHK("return ok", 1, n_ret)
        k = n_cs;
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, A_CTRL, 32'(i));
            bus(1'b1, ch(3, R_MODE), i == 1 ? 32'h0 : 32'h20);
            fire(3, 0, 1, 0);
        end
        `CHK("no switch", k, n_cs)
        `CHK("vint source", 4'h3, vint_idx)
        bus(1'b1, A_STAT, 32'h7);
        cpu_pc <= 16'h2468;
        fire(16, 0, 0, 1);
        `CHK("break switch", {3'h2, 16'h1200, 16'h2468, 16'h0F0F, 1'b1}, cs_q)
        ret(1'b0);
        `CHK("return refused", 1, n_ret)
        rc(A_STAT, 32'h6);
        ret(1'b1);
        `CHK("break return ok", 2, n_ret)
        rc(A_STATE, 32'h15);
        end_of_test();
    end
endmodule : msc_engine_tb

bind msc_engine msc_assertions chk (.ref_clk, .reset_n, .hsel, .htrans, .hready, .hrdata,
    .hreadyout, .mem_req, .mem_valid, .mem_ack, .cpu_pc, .cpu_psw, .bank_vec, .brk_operand,
    .bank_sel, .cs_info, .cs_stb, .vint_stb);
`default_nettype wire
